// >>> hw/tpp_top.v
/*
 * Timer-based pulse-width pair: two identical channels, each an 8-bit
 * counter with selectable modulus, a write-only duty reference, an
 * overflow flag with interrupt enable and a pin multiplexer that hands
 * the pin to the waveform or to general-purpose I/O.
 * Assumes every control input comes from CPU-side logic on MCLK, so no
 * input is synchronised. Write strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpp_regs.vh"

module tpp_top (
    // clock and reset
    input  wire       MCLK,
    input  wire       SRST,

    // channel 0 timer control
    input  wire       TIMER_RUN_CH0,
    input  wire [2:0] CLOCK_RATE_FIELD_CH0,
    input  wire       RANGE_SEL_HI_CH0,
    input  wire       RANGE_SEL_LO_CH0,
    input  wire       PULSE_PIN_ENABLE_CH0,
    input  wire       OVERFLOW_IRQ_ENABLE_CH0,
    // channel 0 software access
    input  wire       COUNT_WR_CH0,
    input  wire [7:0] COUNT_WDATA_CH0,
    input  wire       DUTY_WR_CH0,
    input  wire [7:0] DUTY_WDATA_CH0,
    input  wire       FLAG_CLR_CH0,
    // channel 0 general-purpose pin drive
    input  wire       GPIO_OUT_CH0,
    input  wire       GPIO_OE_CH0,
    // channel 0 status and pin
    output wire [7:0] COUNT_VALUE_CH0,
    output wire       OVERFLOW_FLAG_CH0,
    output wire       OVERFLOW_IRQ_CH0,
    output wire       PIN_OUT_CH0,
    output wire       PIN_OE_CH0,

    // channel 1 timer control
    input  wire       TIMER_RUN_CH1,
    input  wire [2:0] CLOCK_RATE_FIELD_CH1,
    input  wire       RANGE_SEL_HI_CH1,
    input  wire       RANGE_SEL_LO_CH1,
    input  wire       PULSE_PIN_ENABLE_CH1,
    input  wire       OVERFLOW_IRQ_ENABLE_CH1,
    // channel 1 software access
    input  wire       COUNT_WR_CH1,
    input  wire [7:0] COUNT_WDATA_CH1,
    input  wire       DUTY_WR_CH1,
    input  wire [7:0] DUTY_WDATA_CH1,
    input  wire       FLAG_CLR_CH1,
    // channel 1 general-purpose pin drive
    input  wire       GPIO_OUT_CH1,
    input  wire       GPIO_OE_CH1,
    // channel 1 status and pin
    output wire [7:0] COUNT_VALUE_CH1,
    output wire       OVERFLOW_FLAG_CH1,
    output wire       OVERFLOW_IRQ_CH1,
    output wire       PIN_OUT_CH1,
    output wire       PIN_OE_CH1
);

    localparam NCH = 2;

    // per-channel inputs gathered into vectors for the channel loop
    wire [NCH-1:0]   run_v    = {TIMER_RUN_CH1, TIMER_RUN_CH0};
    wire [3*NCH-1:0] rate_v   = {CLOCK_RATE_FIELD_CH1, CLOCK_RATE_FIELD_CH0};
    wire [NCH-1:0]   hi_v     = {RANGE_SEL_HI_CH1, RANGE_SEL_HI_CH0};
    wire [NCH-1:0]   lo_v     = {RANGE_SEL_LO_CH1, RANGE_SEL_LO_CH0};
    wire [NCH-1:0]   pen_v    = {PULSE_PIN_ENABLE_CH1, PULSE_PIN_ENABLE_CH0};
    wire [NCH-1:0]   ien_v    = {OVERFLOW_IRQ_ENABLE_CH1,
                                 OVERFLOW_IRQ_ENABLE_CH0};
    wire [NCH-1:0]   cwr_v    = {COUNT_WR_CH1, COUNT_WR_CH0};
    wire [8*NCH-1:0] cdat_v   = {COUNT_WDATA_CH1, COUNT_WDATA_CH0};
    wire [NCH-1:0]   rwr_v    = {DUTY_WR_CH1, DUTY_WR_CH0};
    wire [8*NCH-1:0] rdat_v   = {DUTY_WDATA_CH1, DUTY_WDATA_CH0};
    wire [NCH-1:0]   fclr_v   = {FLAG_CLR_CH1, FLAG_CLR_CH0};
    wire [NCH-1:0]   gout_v   = {GPIO_OUT_CH1, GPIO_OUT_CH0};
    wire [NCH-1:0]   goe_v    = {GPIO_OE_CH1, GPIO_OE_CH0};

    // per-channel register outputs
    wire [8*NCH-1:0] cnt_v;
    wire [NCH-1:0]   flag_v;
    wire [NCH-1:0]   irq_v;
    wire [NCH-1:0]   pout_v;
    wire [NCH-1:0]   poe_v;

    // both channels are the same logic on their own timer
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch // R16
            wire       tick;
            wire [7:0] top;
            reg  [7:0] cnt_q;
            reg  [7:0] cnt_d;
            reg  [7:0] ref_q;
            reg  [7:0] ref_d;
            reg        flag_q;
            reg        flag_d;
            reg        irq_q;
            reg        pout_q;
            reg        pout_d;
            reg        poe_q;
            reg        poe_d;
            reg        wrap;
            reg        leave_full;

            tpp_prescale u_pre (
                .clk  (MCLK),
                .srst (SRST),
                .run  (run_v[i]),
                .rate (rate_v[3*i +: 3]),
                .tick (tick)
            );

            tpp_period u_per (
                .range_hi (hi_v[i]),
                .range_lo (lo_v[i]),
                .top      (top)
            );

            // next count: a software write wins over a tick in the same cycle
            always @* begin
                wrap  = 1'b0;
                cnt_d = cnt_q;
                if (cwr_v[i]) begin
                    cnt_d = cdat_v[8*i +: 8]; // R09
                end else if (tick) begin
                    // counts left above the top after a range change
                    // also wrap, so a stray value cannot stall a period
                    if (cnt_q >= top) begin
                        cnt_d = `TPP_CNT_RST; // R01 R18
                        wrap  = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end

            // reference is write-only; takes effect on the next edge
            always @* begin
                ref_d = ref_q;
                if (rwr_v[i]) begin
                    ref_d = rdat_v[8*i +: 8]; // R10 R11
                end
            end

            // overflow flag: a set in the clearing cycle wins
            always @* begin
                leave_full = (cnt_q == `TPP_CNT_FULL) &&
                             (cnt_d != `TPP_CNT_FULL); // R17
                flag_d = wrap || leave_full ||
                         (flag_q && !fclr_v[i]); // R08 R18
            end

            // pin level follows the compare of the values now being stored,
            // so the pin has no lag behind the counter register
            always @* begin
                if (pen_v[i]) begin
                    // zero forces high and equality drops low; a zero
                    // reference therefore stays low all period
                    pout_d = (cnt_d < ref_d); // R03 R04 R05 R06 R13
                    poe_d  = 1'b1;            // R13
                end else begin
                    pout_d = gout_v[i];
                    poe_d  = goe_v[i];
                end
            end

            // channel state registers
            always @(posedge MCLK) begin
                if (SRST) begin
                    cnt_q  <= `TPP_CNT_RST;
                    ref_q  <= `TPP_REF_RST;
                    flag_q <= 1'b0;
                    irq_q  <= 1'b0;
                    pout_q <= 1'b0;
                    poe_q  <= 1'b0;
                end else begin
                    cnt_q  <= cnt_d;
                    ref_q  <= ref_d;
                    flag_q <= flag_d;
                    irq_q  <= flag_d && ien_v[i]; // R15
                    pout_q <= pout_d;
                    poe_q  <= poe_d;
                end
            end

            assign cnt_v[8*i +: 8] = cnt_q;
            assign flag_v[i]       = flag_q;
            assign irq_v[i]        = irq_q;
            assign pout_v[i]       = pout_q;
            assign poe_v[i]        = poe_q;
        end
    endgenerate

    // channel 0 outputs
    assign COUNT_VALUE_CH0   = cnt_v[7:0];
    assign OVERFLOW_FLAG_CH0 = flag_v[0];
    assign OVERFLOW_IRQ_CH0  = irq_v[0];
    assign PIN_OUT_CH0       = pout_v[0];
    assign PIN_OE_CH0        = poe_v[0];

    // channel 1 outputs
    assign COUNT_VALUE_CH1   = cnt_v[15:8];
    assign OVERFLOW_FLAG_CH1 = flag_v[1];
    assign OVERFLOW_IRQ_CH1  = irq_v[1];
    assign PIN_OUT_CH1       = pout_v[1];
    assign PIN_OE_CH1        = poe_v[1];

endmodule
`default_nettype wire

// >>> hw/tpp_regs.vh
/*
 * Constants for the timer-based pulse-width pair: range codes, wrap
 * limits, rate field codes and reset values for both channels.
 * Assumes it is included by bare name from the design files under hw/.
 */
// Behaviour
// [R01] each channel runs an 8-bit counter with modulus 256, 64, 32 or 16
// [R02] range bits hi/lo: 00=256, 01=64 (0x3f), 10=32 (0x1f), 11=16 (0x0f)
// [R03] output goes low when counter equals the duty reference
// [R04] output forced high each time the counter reaches zero
// [R05] output high while counter below reference, low when at or above
// [R06] high fraction of a period equals reference divided by modulus
// [R07] software keeps counter and reference below 0xff when interrupts used
// [R08] overflow flag set once per period, rate follows selected modulus
// [R09] a counter write mid-period is compared at once
// [R10] duty reference is write-only; software writes it from a buffer copy
// [R11] reference writes act at once, possibly giving two highs in a period
// [R12] software should change reference only after overflow flag rises
// [R13] output-enable bit routes waveform to pin, replacing general I/O
// [R14] rate field 110 clocks counter at a quarter CPU rate; run bit starts
// [R15] pulse generation and overflow interrupt may be active together
// [R16] a second identical channel with its own range, reference and pin
// [R17] flag set whenever counter leaves 0xff, by write or while stopped
// [R18] reduced ranges wrap from modulus minus one to zero, as overflow
`ifndef TPP_REGS_VH
`define TPP_REGS_VH

// range select codes, {hi, lo}
`define TPP_RANGE_256     2'b00
`define TPP_RANGE_64      2'b01
`define TPP_RANGE_32      2'b10
`define TPP_RANGE_16      2'b11

// last count before the wrap for each range
`define TPP_TOP_256       8'hff
`define TPP_TOP_64        8'h3f
`define TPP_TOP_32        8'h1f
`define TPP_TOP_16        8'h0f

// counter value whose departure sets the overflow flag
`define TPP_CNT_FULL      8'hff

// rate field: divide is 256 >> field, so 110 gives a quarter rate
`define TPP_RATE_QUARTER  3'b110
`define TPP_RATE_MASK     8'hff

// reset values
`define TPP_CNT_RST       8'h00
`define TPP_REF_RST       8'h00
`define TPP_PRE_RST       8'h00

`endif

// >>> hw/tpp_period.v
/*
 * Range decoder: turns the two range-select bits into the last count of
 * the period. Purely combinational; assumes the bits are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpp_regs.vh"

module tpp_period (
    // range select
    input  wire       range_hi,
    input  wire       range_lo,
    // last count before the wrap
    output reg  [7:0] top
);

    // modulus decode
    always @* begin
        case ({range_hi, range_lo})
            `TPP_RANGE_256: top = `TPP_TOP_256; // R02
            `TPP_RANGE_64:  top = `TPP_TOP_64;  // R02
            `TPP_RANGE_32:  top = `TPP_TOP_32;  // R02
            `TPP_RANGE_16:  top = `TPP_TOP_16;  // R02
            default:        top = `TPP_TOP_256;
        endcase
    end

endmodule
`default_nettype wire

// >>> hw/tpp_prescale.v
/*
 * Rate prescaler for one timer: gives a one-cycle count tick every
 * 256 >> rate cycles of the CPU clock while the run bit is set.
 * Assumes rate and run come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tpp_regs.vh"

module tpp_prescale (
    // clock and reset
    input  wire       clk,
    input  wire       srst,
    // control
    input  wire       run,
    input  wire [2:0] rate,
    // one-cycle count tick
    output reg        tick
);

    reg  [7:0] pre_q;
    wire [7:0] mask = `TPP_RATE_MASK >> rate;
    wire       hit  = (pre_q & mask) == mask;

    // held at zero while stopped so the first period after start is whole
    always @(posedge clk) begin
        if (srst || !run) begin
            pre_q <= `TPP_PRE_RST;
            tick  <= 1'b0;
        end else begin
            pre_q <= pre_q + 8'h01;
            tick  <= hit; // R14
        end
    end

endmodule
`default_nettype wire

// >>> testbench/tpp_props.sv
/* tpp_props: timing checks on channel 0 of the pulse-width pair.
   Assumes it is bound to tpp_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tpp_props (
    // clock and reset
    input wire logic       MCLK,
    input wire logic       SRST,
    // channel 0 inputs
    input wire logic       TIMER_RUN_CH0,
    input wire logic       RANGE_SEL_HI_CH0,
    input wire logic       RANGE_SEL_LO_CH0,
    input wire logic       PULSE_PIN_ENABLE_CH0,
    input wire logic       OVERFLOW_IRQ_ENABLE_CH0,
    input wire logic       COUNT_WR_CH0,
    input wire logic [7:0] COUNT_WDATA_CH0,
    input wire logic       DUTY_WR_CH0,
    input wire logic [7:0] DUTY_WDATA_CH0,
    input wire logic       FLAG_CLR_CH0,
    // channel 0 outputs
    input wire logic [7:0] COUNT_VALUE_CH0,
    input wire logic       OVERFLOW_FLAG_CH0,
    input wire logic       OVERFLOW_IRQ_CH0,
    input wire logic       PIN_OUT_CH0,
    input wire logic       PIN_OE_CH0
);
    logic [7:0] ref_q;
    logic [7:0] top;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    // shadow of the reference, which the ports cannot read back
    always_ff @(posedge MCLK)
        if (SRST) ref_q <= 8'h00;
        else if (DUTY_WR_CH0) ref_q <= DUTY_WDATA_CH0;
    // last count of the selected range
    assign top = RANGE_SEL_HI_CH0 ? (RANGE_SEL_LO_CH0 ? 8'h0f : 8'h1f)
                                  : (RANGE_SEL_LO_CH0 ? 8'h3f : 8'hff);
    chk_count_write: assert property (
        COUNT_WR_CH0 |=> COUNT_VALUE_CH0 == $past(COUNT_WDATA_CH0))
        else $error("count write not loaded");
    chk_pin_compare: assert property (
        !$past(SRST) && $past(PULSE_PIN_ENABLE_CH0) |->
        PIN_OUT_CH0 == (COUNT_VALUE_CH0 < ref_q))
        else $error("pin does not follow compare");
    chk_pin_owned: assert property (
        !$past(SRST) && $past(PULSE_PIN_ENABLE_CH0) |-> PIN_OE_CH0)
        else $error("pin not driven by waveform");
    chk_leave_full: assert property (
        !$past(SRST) && $past(COUNT_VALUE_CH0) == 8'hff &&
        COUNT_VALUE_CH0 != 8'hff |-> OVERFLOW_FLAG_CH0)
        else $error("flag missed on leaving full count");
    chk_range_wrap: assert property (
        !$past(SRST) && !$past(COUNT_WR_CH0) && $changed(COUNT_VALUE_CH0)
        && $past(COUNT_VALUE_CH0) == $past(top) |->
        COUNT_VALUE_CH0 == 8'h00 && OVERFLOW_FLAG_CH0)
        else $error("wrong wrap at range top");
    chk_count_step: assert property (
        !$past(SRST) && !$past(COUNT_WR_CH0) && $changed(COUNT_VALUE_CH0)
        && $past(COUNT_VALUE_CH0) < $past(top) |->
        COUNT_VALUE_CH0 == $past(COUNT_VALUE_CH0) + 8'h01)
        else $error("count did not step by one");
    chk_irq_gate: assert property (
        !$past(SRST) |-> OVERFLOW_IRQ_CH0 ==
        (OVERFLOW_FLAG_CH0 && $past(OVERFLOW_IRQ_ENABLE_CH0)))
        else $error("irq not flag and enable");
    chk_stopped_hold: assert property (
        !TIMER_RUN_CH0 && !$past(TIMER_RUN_CH0) && !COUNT_WR_CH0 |=>
        $stable(COUNT_VALUE_CH0))
        else $error("count moved while stopped");
    chk_flag_sticky: assert property (
        !$past(SRST) && $past(OVERFLOW_FLAG_CH0) && !$past(FLAG_CLR_CH0)
        |-> OVERFLOW_FLAG_CH0)
        else $error("flag dropped without clear");
endmodule
bind tpp_top tpp_props u_props (
    .MCLK                    (MCLK),
    .SRST                    (SRST),
    .TIMER_RUN_CH0           (TIMER_RUN_CH0),
    .RANGE_SEL_HI_CH0        (RANGE_SEL_HI_CH0),
    .RANGE_SEL_LO_CH0        (RANGE_SEL_LO_CH0),
    .PULSE_PIN_ENABLE_CH0    (PULSE_PIN_ENABLE_CH0),
    .OVERFLOW_IRQ_ENABLE_CH0 (OVERFLOW_IRQ_ENABLE_CH0),
    .COUNT_WR_CH0            (COUNT_WR_CH0),
    .COUNT_WDATA_CH0         (COUNT_WDATA_CH0),
    .DUTY_WR_CH0             (DUTY_WR_CH0),
    .DUTY_WDATA_CH0          (DUTY_WDATA_CH0),
    .FLAG_CLR_CH0            (FLAG_CLR_CH0),
    .COUNT_VALUE_CH0         (COUNT_VALUE_CH0),
    .OVERFLOW_FLAG_CH0       (OVERFLOW_FLAG_CH0),
    .OVERFLOW_IRQ_CH0        (OVERFLOW_IRQ_CH0),
    .PIN_OUT_CH0             (PIN_OUT_CH0),
    .PIN_OE_CH0              (PIN_OE_CH0)
);
`default_nettype wire

// >>> testbench/tpp_load.sv
/* tpp_load: load on a pulse-width pin, tallying high cycles.
   Assumes a pull-down on the pin and the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module tpp_load (
    // clock
    input wire logic         clk,
    // pin as driven by the block
    input wire logic         pin_out,
    input wire logic         pin_oe,
    // wire level and high tally
    output var logic         level,
    output var logic [15:0]  high_cnt
);
    // pull-down wins while the pin is released
    assign level = pin_oe ? pin_out : 1'b0;
    // free-running tally; the bench takes differences
    initial high_cnt = 16'h0000;
    always @(posedge clk) high_cnt <= high_cnt + {15'h0000, level};
endmodule
`default_nettype wire

// >>> testbench/tpp_top_test.sv
/* tpp_top_test: directed tests of the pulse-width pair.
   Assumes tpp_top, tpp_load and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tpp_top_test;
    localparam int KC = 0, KD = 1, KF = 2;
    logic mclk, srst;
    logic [1:0] run, rhi, rlo, pen, ien, cwr, dwr, fclr, gout, goe;
    logic [1:0][2:0] rate;
    logic [1:0][7:0] cdat, ddat;
    wire  [1:0][7:0] cv;
    wire  [1:0] flg, irq, pout, poe;
    wire  lvl;
    wire  [15:0] hc;
    int n_errors = 0, samples_checked = 0, cyc = 0, ch, i, t0, h0;
    logic [7:0] cnts [5] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'hff};
    logic [7:0] tops [4] = '{8'hff, 8'h3f, 8'h1f, 8'h0f};
    tpp_top i_dut (.MCLK(mclk), .SRST(srst),
        .TIMER_RUN_CH0(run[0]), .CLOCK_RATE_FIELD_CH0(rate[0]),
        .RANGE_SEL_HI_CH0(rhi[0]), .RANGE_SEL_LO_CH0(rlo[0]),
        .PULSE_PIN_ENABLE_CH0(pen[0]), .OVERFLOW_IRQ_ENABLE_CH0(ien[0]),
        .COUNT_WR_CH0(cwr[0]), .COUNT_WDATA_CH0(cdat[0]),
        .DUTY_WR_CH0(dwr[0]), .DUTY_WDATA_CH0(ddat[0]),
        .FLAG_CLR_CH0(fclr[0]), .GPIO_OUT_CH0(gout[0]), .GPIO_OE_CH0(goe[0]),
        .COUNT_VALUE_CH0(cv[0]), .OVERFLOW_FLAG_CH0(flg[0]),
        .OVERFLOW_IRQ_CH0(irq[0]), .PIN_OUT_CH0(pout[0]), .PIN_OE_CH0(poe[0]),
        .TIMER_RUN_CH1(run[1]), .CLOCK_RATE_FIELD_CH1(rate[1]),
        .RANGE_SEL_HI_CH1(rhi[1]), .RANGE_SEL_LO_CH1(rlo[1]),
        .PULSE_PIN_ENABLE_CH1(pen[1]), .OVERFLOW_IRQ_ENABLE_CH1(ien[1]),
        .COUNT_WR_CH1(cwr[1]), .COUNT_WDATA_CH1(cdat[1]),
        .DUTY_WR_CH1(dwr[1]), .DUTY_WDATA_CH1(ddat[1]),
        .FLAG_CLR_CH1(fclr[1]), .GPIO_OUT_CH1(gout[1]), .GPIO_OE_CH1(goe[1]),
        .COUNT_VALUE_CH1(cv[1]), .OVERFLOW_FLAG_CH1(flg[1]),
        .OVERFLOW_IRQ_CH1(irq[1]), .PIN_OUT_CH1(pout[1]), .PIN_OE_CH1(poe[1]));
    tpp_load i_load (.clk(mclk), .pin_out(pout[0]), .pin_oe(poe[0]),
        .level(lvl), .high_cnt(hc));
    // 100 MHz clock and a cycle count for period checks
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle strobe: count write, duty write or flag clear
    task automatic pulse(input int k, input int c, input logic [7:0] v);
        @(negedge mclk);
        case (k)
            KC: begin cwr[c] = 1'b1; cdat[c] = v; end
            KD: begin dwr[c] = 1'b1; ddat[c] = v; end
            default: fclr[c] = 1'b1;
        endcase
        @(negedge mclk);
        {cwr[c], dwr[c], fclr[c]} = 3'h0;
    endtask
    // bounded wait for the overflow flag
    task automatic wait_flag(input int c, input int lim);
        for (int j = 0; j < lim && flg[c] !== 1'b1; j++) @(negedge mclk);
        chk(flg[c], 16'h0001);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        {run, rhi, rlo, pen, ien, cwr, dwr, fclr, gout, goe} = 20'h00000;
        {rate, cdat, ddat} = 38'h0;
        srst = 1'b1;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        chk(cv, 16'h0000);
        chk({flg, irq, pout, poe}, 16'h0000);
        // timer stopped: compare, flag and pin hand-over per channel
        for (ch = 0; ch < 2; ch++) begin
            pen[ch] = 1'b1;
            pulse(KD, ch, 8'h08);
            for (i = 0; i < 5; i++) begin
                pulse(KC, ch, cnts[i]);
                chk(cv[ch], {8'h00, cnts[i]});
                chk(pout[ch], {15'h0, cnts[i] < 8'h08});
            end
            pulse(KF, ch, 8'h00);
            pulse(KC, ch, 8'h0a);
            chk({flg[ch], pout[ch]}, 16'h0002);
            pulse(KD, ch, 8'h14);
            chk(pout[ch], 16'h0001);
            ien[ch] = 1'b1;
            @(negedge mclk);
            chk(irq[ch], 16'h0001);
            ien[ch] = 1'b0;
            pulse(KF, ch, 8'h00);
            chk({flg[ch], irq[ch]}, 16'h0000);
            {pen[ch], gout[ch], goe[ch]} = 3'b011;
            @(negedge mclk);
            chk({poe[ch], pout[ch]}, 16'h0003);
            goe[ch] = 1'b0;
            @(negedge mclk);
            chk(poe[ch], 16'h0000);
        end
        chk(lvl, 16'h0000);
        // each range wraps from its top to zero; fastest rate
        rate[0] = 3'h7;
        run[0] = 1'b1;
        for (i = 0; i < 4; i++) begin
            {rhi[0], rlo[0]} = i[1:0];
            pulse(KF, 0, 8'h00);
            pulse(KC, 0, tops[i]);
            wait_flag(0, 8);
            chk(cv[0], 16'h0000);
        end
        // range 16, quarter rate, duty 4 loaded after overflow
        rate[0] = 3'h6;
        pen[0] = 1'b1;
        pulse(KD, 0, 8'h04);
        pulse(KF, 0, 8'h00);
        wait_flag(0, 200);
        t0 = cyc;
        h0 = hc;
        pulse(KF, 0, 8'h00);
        wait_flag(0, 80);
        chk(16'(cyc - t0), 16'h0040);
        chk(hc - 16'(h0), 16'h0010);
        // mid-run reset while counting, flag set and pin driven
        repeat (10) @(negedge mclk);
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        chk(cv, 16'h0000);
        chk({flg, irq, pout, poe}, 16'h0000);
        report_and_stop;
    end
endmodule
`default_nettype wire
